// [hdl/cifc_pkg.sv]
`default_nettype none
package cifc_pkg;
   localparam int CIFC_LEVEL_W = 3;
   localparam int CIFC_VEC_W = 6;
   localparam logic CIFC_I_RST = 1'h0;
   localparam logic CIFC_U_RST = 1'h0;
   localparam logic [2:0] CIFC_LEVEL_RST = 3'h0;
   localparam logic CIFC_ISTK_RST = 1'h1;
   localparam logic CIFC_ACCEPT_RST = 1'h0;
   localparam logic [2:0] CIFC_RDATA_RST = 3'h0;
   localparam logic CIFC_RSV_RD = 1'h0;
   localparam logic [5:0] CIFC_SWI_U_MAX = 6'h1F;
   localparam int CIFC_FLG_U = 0;
   localparam int CIFC_FLG_I = 1;
   localparam int CIFC_FLG_RSV = 2;
   typedef enum logic [1:0] {
      CIFC_ACK_NONE,
      CIFC_ACK_HW,
      CIFC_ACK_SW
   } cifc_ack_t;
endpackage : cifc_pkg
`default_nettype wire

// [hdl/cifc_prio_cmp.sv]
`default_nettype none
module cifc_prio_cmp (
   input wire logic [cifc_pkg::CIFC_LEVEL_W-1:0] req_level,
   input wire logic [cifc_pkg::CIFC_LEVEL_W-1:0] cur_level,
   output logic above
);
   import cifc_pkg::*;
   // strictly greater: an equal level stays pending
   assign above = (req_level > cur_level);
endmodule : cifc_prio_cmp
`default_nettype wire

// [hdl/cifc_flags.sv]
// Behaviour
// RQ1: maskable interrupts blocked while enable flag is 0, allowed while 1.
// RQ2: any acknowledged interrupt clears the enable flag to 0.
// RQ3: stack select 0 picks interrupt stack pointer, 1 picks user stack pointer.
// RQ4: hardware ack or software interrupt vector 0..31 clears stack select.
// RQ5: processor priority level is a 3-bit field, levels 0 to 7.
// RQ6: request accepted only when its level exceeds processor priority level; non-maskable requests here skip the level test.
// RQ7: reserved flag bit written as 0; reads return undefined (here 0).
// RQ8: reset clears enable flag, stack select and priority level.
`default_nettype none
module cifc_flags (
   input wire logic clk,
   input wire logic reset_n,
   // software flag write (flag-register restore / explicit write)
   input wire logic flag_wr,
   input wire logic [2:0] flag_wdata,
   input wire logic level_wr,
   input wire logic [cifc_pkg::CIFC_LEVEL_W-1:0] level_wdata,
   // prioritised request from the interrupt request logic
   input wire logic req_valid,
   input wire logic req_maskable,
   input wire logic [cifc_pkg::CIFC_LEVEL_W-1:0] req_level,
   // core reports the ack that actually happened
   input wire logic hw_ack,
   input wire logic sw_int,
   input wire logic [cifc_pkg::CIFC_VEC_W-1:0] sw_vector,
   output logic irq_enable_flag,
   output logic stack_select_flag,
   output logic use_user_stack_pointer,
   output logic use_interrupt_stack_pointer,
   output logic [cifc_pkg::CIFC_LEVEL_W-1:0] processor_priority_level,
   output logic [2:0] flag_rdata,
   output logic accept_req
);
   import cifc_pkg::*;

   logic i_reg;
   logic u_reg;
   logic [CIFC_LEVEL_W-1:0] level_reg;
   logic above;
   logic accept_next;
   logic any_ack;
   logic u_clear;
   logic swi_low;
   cifc_ack_t ack_kind;

   // ------------------------------------------------------------
   // acceptance
   // ------------------------------------------------------------
   cifc_prio_cmp u_cmp (
      .req_level(req_level),
      .cur_level(level_reg),
      .above(above)
   );

   // a hardware ack outranks a software one reported in the same cycle
   always_comb begin
      ack_kind = CIFC_ACK_NONE;
      if (hw_ack) begin
         ack_kind = CIFC_ACK_HW;
      end else if (sw_int) begin
         ack_kind = CIFC_ACK_SW;
      end
   end

   assign swi_low = (sw_vector <= CIFC_SWI_U_MAX);

   always_comb begin
      any_ack = 1'h0;
      u_clear = 1'h0;
      case (ack_kind)
         CIFC_ACK_HW: begin
            any_ack = 1'h1;
            u_clear = 1'h1; // see RQ4
         end
         CIFC_ACK_SW: begin
            any_ack = 1'h1;
            // high vectors keep the current stack
            u_clear = swi_low; // see RQ4
         end
         default: begin
            any_ack = 1'h0;
            u_clear = 1'h0;
         end
      endcase
   end

   // non-maskable requests bypass the enable flag and the level test
   always_comb begin
      accept_next = 1'h0;
      if (req_valid) begin
         if (!req_maskable) begin
            accept_next = 1'h1;
         end else begin
            accept_next = i_reg & above; // see RQ1 see RQ6
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         accept_req <= CIFC_ACCEPT_RST;
      end else begin
         // an ack in flight already clears the enable flag; do not re-accept
         accept_req <= accept_next & ~any_ack; // see RQ2
      end
   end

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   // hardware clear wins over a same-cycle software write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         i_reg <= CIFC_I_RST; // see RQ8
      end else if (any_ack) begin
         i_reg <= 1'h0; // see RQ2
      end else if (flag_wr) begin
         i_reg <= flag_wdata[CIFC_FLG_I];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         u_reg <= CIFC_U_RST; // see RQ8
      end else if (u_clear) begin
         u_reg <= 1'h0; // see RQ4
      end else if (flag_wr) begin
         u_reg <= flag_wdata[CIFC_FLG_U];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_reg <= CIFC_LEVEL_RST; // see RQ8
      end else if (level_wr) begin
         level_reg <= level_wdata; // see RQ5
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_enable_flag <= CIFC_I_RST;
      end else begin
         irq_enable_flag <= i_reg;
      end
   end

   // both selects follow one flag, so the core never sees two stacks chosen
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stack_select_flag <= CIFC_U_RST;
         use_user_stack_pointer <= CIFC_U_RST;
         use_interrupt_stack_pointer <= CIFC_ISTK_RST;
      end else begin
         stack_select_flag <= u_reg;
         use_user_stack_pointer <= u_reg; // see RQ3
         use_interrupt_stack_pointer <= ~u_reg; // see RQ3
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         processor_priority_level <= CIFC_LEVEL_RST;
      end else begin
         processor_priority_level <= level_reg; // see RQ5
      end
   end

   // reserved bit ignored on write; a fixed zero on read beats leaking stale data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_rdata <= CIFC_RDATA_RST;
      end else begin
         flag_rdata[CIFC_FLG_I] <= i_reg;
         flag_rdata[CIFC_FLG_U] <= u_reg;
         flag_rdata[CIFC_FLG_RSV] <= CIFC_RSV_RD; // see RQ7
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_mask_blocks: assert property (@(posedge clk) disable iff (!reset_n) // see RQ1
      (req_valid && req_maskable && !i_reg) |=> !accept_req)
      else $error("maskable request accepted while disabled");
   chk_level_strict: assert property (@(posedge clk) disable iff (!reset_n) // see RQ6
      (req_valid && req_maskable && req_level <= level_reg) |=> !accept_req)
      else $error("request at or below level accepted");
   chk_accept_ok: assert property (@(posedge clk) disable iff (!reset_n) // see RQ6
      (req_valid && req_maskable && i_reg && req_level > level_reg && !hw_ack && !sw_int) |=> accept_req)
      else $error("eligible request not accepted");
   chk_ack_clears_i: assert property (@(posedge clk) disable iff (!reset_n) // see RQ2
      (hw_ack || sw_int) |=> ##1 !irq_enable_flag)
      else $error("enable flag not cleared by ack");
   chk_hw_clears_u: assert property (@(posedge clk) disable iff (!reset_n) // see RQ4
      hw_ack |=> !u_reg)
      else $error("stack select not cleared by hardware ack");
   chk_swi_low_u: assert property (@(posedge clk) disable iff (!reset_n) // see RQ4
      (sw_int && sw_vector <= CIFC_SWI_U_MAX) |=> ##1 !stack_select_flag)
      else $error("low software vector kept stack select");
   chk_swi_high_u: assert property (@(posedge clk) disable iff (!reset_n) // see RQ4
      (sw_int && sw_vector > CIFC_SWI_U_MAX && !hw_ack && !flag_wr) |=> $stable(u_reg))
      else $error("high software vector changed stack select");
   chk_stack_pick: assert property (@(posedge clk) disable iff (!reset_n) // see RQ3
      use_user_stack_pointer == $past(u_reg) && use_interrupt_stack_pointer == !$past(u_reg))
      else $error("stack pointer select mismatch");
   chk_level_write: assert property (@(posedge clk) disable iff (!reset_n) // see RQ5
      level_wr |=> ##1 processor_priority_level == $past(level_wdata, 2))
      else $error("priority level write lost");
   chk_rsv_zero: assert property (@(posedge clk) disable iff (!reset_n) // see RQ7
      flag_rdata[CIFC_FLG_RSV] == CIFC_RSV_RD)
      else $error("reserved bit reads nonzero");
   chk_ack_no_accept: assert property (@(posedge clk) disable iff (!reset_n) // see RQ2
      (hw_ack || sw_int) |=> !accept_req)
      else $error("request accepted in an ack cycle");
   chk_nonmask_pass: assert property (@(posedge clk) disable iff (!reset_n) // see RQ1
      (req_valid && !req_maskable && !hw_ack && !sw_int) |=> accept_req)
      else $error("non-maskable request not accepted");
   chk_level_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RQ5
      !level_wr |=> $stable(level_reg))
      else $error("priority level changed without a write");
   chk_enable_set: assert property (@(posedge clk) disable iff (!reset_n) // see RQ1
      (flag_wr && flag_wdata[CIFC_FLG_I] && !hw_ack && !sw_int) |=> i_reg)
      else $error("enable flag write lost");
   chk_enable_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RQ2
      (!flag_wr && !hw_ack && !sw_int) |=> $stable(i_reg))
      else $error("enable flag changed without write or ack");
   chk_user_set: assert property (@(posedge clk) disable iff (!reset_n) // see RQ3
      (flag_wr && flag_wdata[CIFC_FLG_U] && !u_clear) |=> u_reg)
      else $error("stack select write lost");
endmodule : cifc_flags
`default_nettype wire

// [bench/cifc_req_model.sv]
`default_nettype none
module cifc_req_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [4:0] cmd,
   output logic req_valid,
   output logic req_maskable,
   output logic [2:0] req_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle lines toggle so a stale level never looks live
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_valid <= 1'h0;
         req_maskable <= 1'h0;
         req_level <= 3'h0;
      end else begin
         req_valid <= cmd[4];
         req_maskable <= cmd[4] ? cmd[3] : ~req_maskable;
         req_level <= cmd[4] ? cmd[2:0] : ~req_level;
      end
   end
endmodule : cifc_req_model
`default_nettype wire

// [bench/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic [3:0] strb = 4'h0;
   logic [4:0] cmd = 5'h00;
   logic [2:0] wd = 3'h0;
   logic [5:0] vec = 6'h00;
   logic rv, rm, i_f, u_f, use_u, use_i, acc;
   logic [2:0] rl, lvl, rdata;
   int n_mismatch = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   cifc_req_model u_req (.clk(clk), .reset_n(reset_n), .cmd(cmd), .req_valid(rv), .req_maskable(rm),
      .req_level(rl));
   cifc_flags u_dut (.clk(clk), .reset_n(reset_n), .flag_wr(strb[3]), .flag_wdata(wd), .level_wr(strb[2]),
      .level_wdata(wd), .req_valid(rv), .req_maskable(rm), .req_level(rl), .hw_ack(strb[1]),
      .sw_int(strb[0]), .sw_vector(vec), .irq_enable_flag(i_f), .stack_select_flag(u_f),
      .use_user_stack_pointer(use_u), .use_interrupt_stack_pointer(use_i),
      .processor_priority_level(lvl), .flag_rdata(rdata), .accept_req(acc));
   task check(input string what, input logic [2:0] exp, input logic [2:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one-cycle strobes, then wait out the two-edge output lag
   task op(input logic [3:0] s, input logic [2:0] d, input logic [5:0] v, input logic [4:0] r);
      @(posedge clk);
      strb <= s;
      wd <= d;
      vec <= v;
      cmd <= r;
      @(posedge clk);
      strb <= 4'h0;
      repeat (3) @(posedge clk);
      #1;
   endtask : op
   task flags_chk(input logic [1:0] f);
      check("flags", {1'h0, f}, {1'h0, i_f, u_f});
      check("rdata", {1'h0, f}, rdata);
      check("stack", {1'h0, f[0], ~f[0]}, {1'h0, use_u, use_i});
   endtask : flags_chk
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'h1;
      #1;
      flags_chk(2'h0);
      check("level", 3'h0, lvl);
      op(4'h8, 3'h3, 6'h00, 5'h00);
      flags_chk(2'h3);
      for (int k = 0; k < 8; k++) begin
         op(4'h4, k[2:0], 6'h00, 5'h00);
         check("level", k[2:0], lvl);
      end
      $display("test flags done");
      op(4'h4, 3'h3, 6'h00, 5'h00);
      for (int k = 0; k < 8; k++) begin
         op(4'h0, 3'h0, 6'h00, {2'h3, k[2:0]});
         check("accept", {2'h0, k > 3}, {2'h0, acc});
      end
      op(4'h8, 3'h1, 6'h00, 5'h1F);
      check("accept", 3'h0, {2'h0, acc});
      op(4'h8, 3'h3, 6'h00, 5'h1F);
      check("accept", 3'h1, {2'h0, acc});
      op(4'h2, 3'h0, 6'h00, 5'h1F);
      flags_chk(2'h0);
      check("accept", 3'h0, {2'h0, acc});
      $display("test accept done");
      for (int v = 31; v < 33; v++) begin
         op(4'h8, 3'h3, 6'h00, 5'h00);
         op(4'h1, 3'h0, v[5:0], 5'h00);
         flags_chk({1'h0, v > 31});
      end
      $display("test swint done");
      // non-maskable request passes with the enable flag clear and level 3
      op(4'h0, 3'h0, 6'h00, 5'h10);
      check("accept", 3'h1, {2'h0, acc});
      $display("test nonmask done");
      // load nonzero state, then reset in mid-run with no request pending
      op(4'h4, 3'h5, 6'h00, 5'h00);
      op(4'h8, 3'h3, 6'h00, 5'h00);
      flags_chk(2'h3);
      check("level", 3'h5, lvl);
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      flags_chk(2'h0);
      check("level", 3'h0, lvl);
      check("accept", 3'h0, {2'h0, acc});
      $display("test reset done");
      end_sim();
   end
   initial begin
      #20000;
      n_mismatch++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
